/* logic/pdsm_map.sv */
// Program/data space access map: table reads, visibility window, X/Y split.
// Assumes core logic on pclk drives requests and that program flash and
// data RAMs answer combinationally to the registered addresses.
`timescale 1ns/1ps
`include "pdsm_params.svh"

module pdsm_map (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   input wire pdsm_pkg::pdsm_req_s req,
   input wire pdsm_pkg::pdsm_rpt_s rpt,
   output logic prog_rd,
   output logic [23:0] prog_addr,
   input wire logic [23:0] prog_word,
   output logic xram_rd,
   output logic xram_wr,
   output logic [1:0] xram_be,
   output logic [15:0] xram_addr,
   output logic [15:0] xram_wdata,
   input wire logic [15:0] xram_rdata,
   output logic yram_rd,
   output logic [15:0] yram_addr,
   input wire logic [15:0] yram_rdata,
   output logic rsp_valid,
   output pdsm_pkg::pdsm_rsp_s rsp
);
   import pdsm_pkg::*;

   logic psv_en_r;
   logic [7:0] page_r;
   logic [15:0] xmod_start_r, xmod_end_r, ymod_start_r, ymod_end_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;
   logic prog_rd_r, xram_rd_r, xram_wr_r, yram_rd_r;
   logic [23:0] prog_addr_r;
   logic [1:0] xram_be_r;
   logic [15:0] xram_addr_r, xram_wdata_r, yram_addr_r;
   logic s1_valid_r, s1_byte_r, s1_hi_r, s1_xzero_r, s1_yzero_r;
   logic s1_prog_r, s1_mapped_r;
   pdsm_kind_e s1_kind_r;
   logic [1:0] s1_extra_r;
   logic rsp_valid_r;
   pdsm_rsp_s rsp_r;
   logic [1:0] last_extra_r;

   logic [15:0] ea_x_eff, ea_y_eff;
   logic x_in_y, x_phys, y_in_y, psv_hit, rd_kind;
   logic prog_rd_nxt, xram_rd_nxt, xram_wr_nxt, yram_rd_nxt;
   logic [23:0] prog_addr_nxt;
   logic [1:0] be_nxt, extra_nxt;
   logic [15:0] wdata_nxt;
   logic xzero_nxt, yzero_nxt;
   logic [15:0] x_word, x_data_nxt;
   logic [31:0] rd_mux;
   logic rd_hit, apb_wr;

   function automatic logic [7:0] brev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         brev8[i] = v[7 - i];
      end
   endfunction

   // APB: zero wait states, ready raised in the first access cycle
   assign apb_wr = psel && penable && pready_r && pwrite;

   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `PDSM_OFS_CTRL: rd_mux[`PDSM_CTRL_PSV_BIT] = psv_en_r;
         `PDSM_OFS_PAGE: rd_mux[7:0] = page_r;
         `PDSM_OFS_XMOD: rd_mux = {xmod_end_r, xmod_start_r};
         `PDSM_OFS_YMOD: rd_mux = {ymod_end_r, ymod_start_r};
         `PDSM_OFS_STAT: rd_mux = {6'h00, last_extra_r, prog_addr_r};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= psel && !penable;
         prdata_r <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
         pslverr_r <= psel && !penable && !rd_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psv_en_r <= 1'b0;
         page_r <= `PDSM_PAGE_RST;
         xmod_start_r <= `PDSM_MOD_START_RST;
         xmod_end_r <= `PDSM_MOD_END_RST;
         ymod_start_r <= `PDSM_MOD_START_RST;
         ymod_end_r <= `PDSM_MOD_END_RST;
      end else if (apb_wr) begin
         case (paddr)
            `PDSM_OFS_CTRL: psv_en_r <= pwdata[`PDSM_CTRL_PSV_BIT];
            `PDSM_OFS_PAGE: page_r <= pwdata[7:0];
            `PDSM_OFS_XMOD: begin
               xmod_start_r <= pwdata[15:0];
               xmod_end_r <= pwdata[31:16];
            end
            `PDSM_OFS_YMOD: begin
               ymod_start_r <= pwdata[15:0];
               ymod_end_r <= pwdata[31:16];
            end
            default: ;
         endcase
      end
   end

   // Address generation and space decode
   always_comb begin
      ea_x_eff = req.ea_x;
      if (req.mod_en && req.ea_x > xmod_end_r) begin
         ea_x_eff = xmod_start_r;
      end
      // Reversal only on the write path; reads keep linear order
      if (req.kind == PDSM_K_DATA_WR && req.brev_en) begin
         ea_x_eff = {ea_x_eff[15:9], brev8(ea_x_eff[8:1]), ea_x_eff[0]};
      end
      ea_y_eff = req.ea_y;
      if (req.mod_en && req.ea_y > ymod_end_r) begin
         ea_y_eff = ymod_start_r;
      end
      x_in_y = ea_x_eff >= `PDSM_Y_BASE && ea_x_eff <= `PDSM_Y_TOP;
      x_phys = ea_x_eff <= `PDSM_RAM_TOP;
      y_in_y = ea_y_eff >= `PDSM_Y_BASE && ea_y_eff <= `PDSM_Y_TOP;
      rd_kind = req.kind == PDSM_K_DATA_RD || req.kind == PDSM_K_MAC_RD;
      // Table kinds never qualify, so the window is off during them
      psv_hit = req_valid && rd_kind && psv_en_r && ea_x_eff[15];
      if (req.kind == PDSM_K_MAC_RD && req.x_ptr[1]) begin
         psv_hit = 1'b0;
      end
   end

   always_comb begin
      prog_rd_nxt = 1'b0;
      xram_rd_nxt = 1'b0;
      xram_wr_nxt = 1'b0;
      yram_rd_nxt = 1'b0;
      xzero_nxt = 1'b0;
      yzero_nxt = 1'b1;
      be_nxt = 2'h3;
      wdata_nxt = req.wdata;
      // Page above, data offset below; bit 23 stays clear in user space
      prog_addr_nxt = {1'b0, page_r, ea_x_eff[14:0]};
      if (req.byte_op) begin
         be_nxt = ea_x_eff[0] ? 2'h2 : 2'h1;
         wdata_nxt = {req.wdata[7:0], req.wdata[7:0]};
      end
      case (req.kind)
         PDSM_K_DATA_RD: begin
            // One linear space, Y included
            if (psv_hit) prog_rd_nxt = 1'b1;
            else if (x_phys) xram_rd_nxt = 1'b1;
            else xzero_nxt = 1'b1;
         end
         PDSM_K_MAC_RD: begin
            // Both paths fire together only here
            if (req.x_ptr[1] || x_in_y) xzero_nxt = 1'b1;
            else if (psv_hit) prog_rd_nxt = 1'b1;
            else if (x_phys) xram_rd_nxt = 1'b1;
            else xzero_nxt = 1'b1;
            if (req.y_ptr[1] && y_in_y) begin
               yram_rd_nxt = 1'b1;
               yzero_nxt = 1'b0;
            end
         end
         PDSM_K_DATA_WR: begin
            // Write-back and data stores use the X bus only; table writes drive nothing
            xram_wr_nxt = x_phys;
         end
         PDSM_K_TBL_RDL, PDSM_K_TBL_RDH: begin
            prog_rd_nxt = 1'b1;
            prog_addr_nxt = {req.tblpag, req.ea_x};
         end
         default: ;
      endcase
   end

   // Extra cycles charged to a mapped read
   always_comb begin
      extra_nxt = `PDSM_XTRA_NONE;
      if (psv_hit) begin
         if (!rpt.in_repeat) begin
            extra_nxt = req.cls_short ? `PDSM_XTRA_ONE : `PDSM_XTRA_TWO;
         end else if (rpt.first || rpt.last || rpt.irq_exit || rpt.reenter) begin
            extra_nxt = `PDSM_XTRA_TWO;
         end else begin
            extra_nxt = `PDSM_XTRA_NONE;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_rd_r <= 1'b0;
         prog_addr_r <= 24'h00_0000;
         xram_rd_r <= 1'b0;
         xram_wr_r <= 1'b0;
         xram_be_r <= 2'h0;
         xram_addr_r <= 16'h0000;
         xram_wdata_r <= 16'h0000;
         yram_rd_r <= 1'b0;
         yram_addr_r <= 16'h0000;
      end else begin
         prog_rd_r <= req_valid && prog_rd_nxt;
         xram_rd_r <= req_valid && xram_rd_nxt;
         xram_wr_r <= req_valid && xram_wr_nxt;
         yram_rd_r <= req_valid && yram_rd_nxt;
         if (req_valid) begin
            prog_addr_r <= prog_addr_nxt;
            xram_be_r <= be_nxt;
            xram_addr_r <= {ea_x_eff[15:1], 1'b0};
            xram_wdata_r <= wdata_nxt;
            yram_addr_r <= {ea_y_eff[15:1], 1'b0};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_valid_r <= 1'b0;
         s1_kind_r <= PDSM_K_IDLE;
         s1_byte_r <= 1'b0;
         s1_hi_r <= 1'b0;
         s1_xzero_r <= 1'b0;
         s1_yzero_r <= 1'b1;
         s1_prog_r <= 1'b0;
         s1_mapped_r <= 1'b0;
         s1_extra_r <= `PDSM_XTRA_NONE;
      end else begin
         s1_valid_r <= req_valid && (rd_kind || req.kind == PDSM_K_TBL_RDL
                                     || req.kind == PDSM_K_TBL_RDH);
         s1_kind_r <= req.kind;
         s1_byte_r <= req.byte_op;
         s1_hi_r <= ea_x_eff[0];
         s1_xzero_r <= xzero_nxt;
         s1_yzero_r <= yzero_nxt;
         s1_prog_r <= prog_rd_nxt;
         s1_mapped_r <= psv_hit;
         s1_extra_r <= extra_nxt;
      end
   end

   // Return path: pick the word, then the byte
   always_comb begin
      case (s1_kind_r)
         PDSM_K_TBL_RDL: x_word = prog_word[15:0];
         PDSM_K_TBL_RDH: x_word = {8'h00, prog_word[23:16]};
         default: x_word = s1_prog_r ? prog_word[15:0] : xram_rdata;
      endcase
      if (s1_xzero_r) x_word = 16'h0000;
      x_data_nxt = x_word;
      if (s1_byte_r) begin
         x_data_nxt = {8'h00, s1_hi_r ? x_word[15:8] : x_word[7:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_valid_r <= 1'b0;
         rsp_r <= '0;
         last_extra_r <= `PDSM_XTRA_NONE;
      end else begin
         rsp_valid_r <= s1_valid_r;
         if (s1_valid_r) begin
            rsp_r.x_data <= x_data_nxt;
            rsp_r.y_data <= s1_yzero_r ? 16'h0000 : yram_rdata;
            rsp_r.extra <= s1_extra_r;
            rsp_r.mapped <= s1_mapped_r;
            last_extra_r <= s1_extra_r;
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prog_rd = prog_rd_r;
   assign prog_addr = prog_addr_r;
   assign xram_rd = xram_rd_r;
   assign xram_wr = xram_wr_r;
   assign xram_be = xram_be_r;
   assign xram_addr = xram_addr_r;
   assign xram_wdata = xram_wdata_r;
   assign yram_rd = yram_rd_r;
   assign yram_addr = yram_addr_r;
   assign rsp_valid = rsp_valid_r;
   assign rsp = rsp_r;

   // Helpers for the checks below
   logic [15:0] ea_q_r;
   logic [7:0] page_q_r, tblpag_q_r;
   logic [23:0] pw_q_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ea_q_r <= 16'h0000;
         page_q_r <= 8'h00;
         tblpag_q_r <= 8'h00;
         pw_q_r <= 24'h00_0000;
      end else begin
         ea_q_r <= req.ea_x;
         page_q_r <= page_r;
         tblpag_q_r <= req.tblpag;
         pw_q_r <= prog_word;
      end
   end

   sequence s_psv_rd;
      req_valid && req.kind == PDSM_K_DATA_RD && !req.mod_en
         && psv_en_r && req.ea_x[15];
   endsequence

   sequence s_mac_bad_x;
      req_valid && req.kind == PDSM_K_MAC_RD && req.x_ptr[1];
   endsequence

   a_psv_addr_map: assert property (@(posedge pclk) disable iff (!presetn)
      s_psv_rd |=> prog_rd_r && prog_addr_r[14:0] == ea_q_r[14:0]
         && prog_addr_r[22:15] == page_q_r && !prog_addr_r[23])
      else $error("mapped read address wrong");

   a_psv_off_gate: assert property (@(posedge pclk) disable iff (!presetn)
      req_valid && req.kind == PDSM_K_DATA_RD && !psv_en_r |=> !prog_rd_r)
      else $error("program read without enable");

   a_tbl_addr_form: assert property (@(posedge pclk) disable iff (!presetn)
      req_valid && req.kind == PDSM_K_TBL_RDL |=> prog_rd_r
         && prog_addr_r == {tblpag_q_r, ea_q_r})
      else $error("table address not from table page");

   a_rdl_word_path: assert property (@(posedge pclk) disable iff (!presetn)
      s1_valid_r && s1_kind_r == PDSM_K_TBL_RDL && !s1_byte_r
         |=> rsp_valid_r && rsp_r.x_data == pw_q_r[15:0])
      else $error("low word not returned");

   a_rdh_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      s1_valid_r && s1_kind_r == PDSM_K_TBL_RDH
         |=> rsp_r.x_data[15:8] == 8'h00)
      else $error("high read upper byte not zero");

   a_mac_cross_zero: assert property (@(posedge pclk) disable iff (!presetn)
      s_mac_bad_x |-> ##1 !xram_rd_r && !prog_rd_r
         ##1 rsp_valid_r && rsp_r.x_data == 16'h0000)
      else $error("crossed pointer did not read zero");

   a_extra_one_cyc: assert property (@(posedge pclk) disable iff (!presetn)
      psv_hit && req.cls_short && !rpt.in_repeat
         |-> ##2 rsp_valid_r && rsp_r.extra == `PDSM_XTRA_ONE)
      else $error("short class mapped cost not one");

   a_extra_rpt_mid: assert property (@(posedge pclk) disable iff (!presetn)
      psv_hit && rpt.in_repeat && !rpt.first && !rpt.last
         && !rpt.irq_exit && !rpt.reenter
         |-> ##2 rsp_valid_r && rsp_r.extra == `PDSM_XTRA_NONE)
      else $error("mid repeat mapped cost not zero");

   a_wr_x_only: assert property (@(posedge pclk) disable iff (!presetn)
      req_valid && req.kind == PDSM_K_DATA_WR && x_phys
         |=> xram_wr_r && !yram_rd_r && !prog_rd_r)
      else $error("write not on X bus");

endmodule

/* logic/pdsm_params.svh */
// Offsets, field positions, reset values and data-space bounds for the
// program/data space access map. Included by the package and the design.
`ifndef PDSM_PARAMS_SVH
`define PDSM_PARAMS_SVH

// APB register byte offsets
`define PDSM_OFS_CTRL 8'h00
`define PDSM_OFS_PAGE 8'h04
`define PDSM_OFS_XMOD 8'h08
`define PDSM_OFS_YMOD 8'h0C
`define PDSM_OFS_STAT 8'h10

// Field positions and reset values
`define PDSM_CTRL_PSV_BIT 0
`define PDSM_PAGE_RST 8'h00
`define PDSM_MOD_START_RST 16'h0000
`define PDSM_MOD_END_RST 16'hFFFE

// Data-space layout: Y block inside X, physical RAM top
`define PDSM_Y_BASE 16'h0800
`define PDSM_Y_TOP 16'h0BFF
`define PDSM_RAM_TOP 16'h0BFF

// Extra instruction cycles for mapped accesses
`define PDSM_XTRA_NONE 2'h0
`define PDSM_XTRA_ONE 2'h1
`define PDSM_XTRA_TWO 2'h2

`endif

/* logic/pdsm_pkg.sv */
// Types shared by the access map and its surroundings.
// Assumes pdsm_params.svh is on the include path.
`include "pdsm_params.svh"

package pdsm_pkg;

   typedef enum logic [2:0] {
      PDSM_K_IDLE = 3'b000,
      PDSM_K_DATA_RD = 3'b001,
      PDSM_K_DATA_WR = 3'b010,
      PDSM_K_MAC_RD = 3'b011,
      PDSM_K_TBL_RDL = 3'b100,
      PDSM_K_TBL_RDH = 3'b101,
      PDSM_K_TBL_WR = 3'b110
   } pdsm_kind_e;

   // Pointer code: 00/01 x_pointer_a/b, 10/11 y_pointer_a/b
   typedef struct packed {
      pdsm_kind_e kind;
      logic byte_op;
      logic cls_short;
      logic [15:0] ea_x;
      logic [1:0] x_ptr;
      logic [15:0] ea_y;
      logic [1:0] y_ptr;
      logic [7:0] tblpag;
      logic [15:0] wdata;
      logic mod_en;
      logic brev_en;
   } pdsm_req_s;

   typedef struct packed {
      logic in_repeat;
      logic first;
      logic last;
      logic irq_exit;
      logic reenter;
   } pdsm_rpt_s;

   typedef struct packed {
      logic [15:0] x_data;
      logic [15:0] y_data;
      logic [1:0] extra;
      logic mapped;
   } pdsm_rsp_s;

endpackage

/* verif/pdsm_map_test.sv */
// Self-checking bench for pdsm_map: registers, table reads, window, X/Y.
// Assumes pdsm_mem_model answers the memory ports.
`timescale 1ns/1ps
`include "pdsm_params.svh"

module pdsm_map_test;
   import pdsm_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr, pg;
   logic [31:0] pwdata, prdata, rd;
   logic req_valid, prog_rd, xram_rd, xram_wr, yram_rd, rsp_valid;
   pdsm_req_s req, rq;
   pdsm_rpt_s rpt, rp;
   pdsm_rsp_s rsp, ex;
   logic [23:0] prog_addr, prog_word, pa, w;
   logic [1:0] xram_be;
   logic [15:0] xram_addr, xram_wdata, xram_rdata, yram_addr, yram_rdata;
   logic [15:0] xa, ya;
   int mismatches, checks, i;
   // Class short, repeat flags, extra cycles
   logic [7:0] xt [7] = '{8'h81, 8'h02, 8'h62, 8'hD2, 8'h4A, 8'hC6, 8'hC0};
   logic [1:0] xps [4] = '{2'b00, 2'b10, 2'b01, 2'b01};
   logic [1:0] yps [4] = '{2'b10, 2'b11, 2'b01, 2'b11};

   pdsm_map uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_valid(req_valid), .req(req), .rpt(rpt), .prog_rd(prog_rd),
      .prog_addr(prog_addr), .prog_word(prog_word), .xram_rd(xram_rd),
      .xram_wr(xram_wr), .xram_be(xram_be), .xram_addr(xram_addr),
      .xram_wdata(xram_wdata), .xram_rdata(xram_rdata), .yram_rd(yram_rd),
      .yram_addr(yram_addr), .yram_rdata(yram_rdata),
      .rsp_valid(rsp_valid), .rsp(rsp));

   pdsm_mem_model mem (.prog_rd(prog_rd), .prog_addr(prog_addr),
      .prog_word(prog_word), .xram_rd(xram_rd), .xram_addr(xram_addr),
      .xram_rdata(xram_rdata), .yram_rd(yram_rd), .yram_addr(yram_addr),
      .yram_rdata(yram_rdata));

   function automatic logic [23:0] pw(input logic [23:0] a);
      return {a[8:1] ^ 8'h5A, a[15:0] ^ 16'h3C96};
   endfunction

   function automatic logic [15:0] tbl(input logic hi, b, s,
         input logic [23:0] p);
      if (!hi)
         return b ? {8'h00, s ? p[15:8] : p[7:0]} : p[15:0];
      return (b && s) ? 16'h0000 : {8'h00, p[23:16]};
   endfunction

   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Zero-wait slave, but the wait is open-ended; watchdog bounds it
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Strobes {prog, xrd, xwr, yrd} under mask m, response two cycles on
   task automatic send(input logic [3:0] e, m, input logic v);
      @(posedge pclk);
      req_valid <= 1'b1;
      req <= rq;
      rpt <= rp;
      @(posedge pclk);
      req_valid <= 1'b0;
      @(posedge pclk);
      chk(({prog_rd, xram_rd, xram_wr, yram_rd} & m) === (e & m), "strobe");
      if (e[3])
         chk(prog_addr === pa, "prog_addr");
      if ((e[2] | e[1]) & m[2])
         chk(xram_addr === xa, "xram_addr");
      if (e[1])
         chk({xram_be, xram_wdata} === (rq.byte_op
            ? {rq.ea_x[0], ~rq.ea_x[0], {2{rq.wdata[7:0]}}}
            : {2'b11, rq.wdata}), "xram write");
      if (e[0] & m[0])
         chk(yram_addr === ya, "yram_addr");
      @(posedge pclk);
      chk(rsp_valid === v, "rsp_valid");
      if (v)
         chk(rsp === ex, "rsp");
   endtask

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   initial begin
      #400000;
      mismatches++;
      conclude();
   end

   initial begin
      {presetn, psel, penable, pwrite, req_valid} = '0;
      {paddr, pwdata} = '0;
      req = '0;
      rpt = '0;
      void'($urandom(32'hCBD78FF2));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `PDSM_OFS_CTRL, 0);
      chk(rd === 32'h0 && er === 1'b0, "ctrl reset");
      apb(0, `PDSM_OFS_PAGE, 0);
      chk(rd === 32'h0, "page reset");
      apb(0, `PDSM_OFS_XMOD, 0);
      chk(rd === {`PDSM_MOD_END_RST, `PDSM_MOD_START_RST}, "xmod");
      apb(1, 8'h14, 32'hFFFFFFFF);
      chk(rd === 32'h0 && er === 1'b1, "unmapped");
      apb(1, `PDSM_OFS_STAT, 32'hFFFFFFFF);
      apb(0, `PDSM_OFS_STAT, 0);
      chk(rd === 32'h0, "stat read-only");
      pg = 8'($urandom);
      apb(1, `PDSM_OFS_PAGE, {24'hFFFFFF, pg});
      apb(0, `PDSM_OFS_PAGE, 0);
      chk(rd === {24'h0, pg}, "page width");
      apb(1, `PDSM_OFS_CTRL, 32'h1);
      apb(0, `PDSM_OFS_CTRL, 0);
      chk(rd === 32'h1, "ctrl enable");
      // Table reads with the window on and address MSB set
      for (i = 0; i < 8; i++) begin
         rq = '0;
         rp = '0;
         rq.kind = i[0] ? PDSM_K_TBL_RDH : PDSM_K_TBL_RDL;
         rq.byte_op = i[1];
         rq.ea_x = {1'b1, 15'($urandom)};
         rq.tblpag = 8'($urandom);
         pa = {rq.tblpag, rq.ea_x};
         ex = '0;
         ex.x_data = tbl(i[0], i[1], rq.ea_x[0], pw(pa));
         send(4'b1000, 4'b1000, 1'b1);
      end
      // Mapped data reads over every cycle-cost case
      for (i = 0; i < 7; i++) begin
         rq = '0;
         rq.kind = PDSM_K_DATA_RD;
         rq.cls_short = xt[i][7];
         rq.ea_x = {1'b1, 14'($urandom), 1'b0};
         rp = xt[i][6:2];
         pa = {1'b0, pg, rq.ea_x[14:0]};
         w = pw(pa);
         ex = '0;
         ex.x_data = w[15:0];
         ex.extra = xt[i][1:0];
         ex.mapped = 1'b1;
         send(4'b1000, 4'b1000, 1'b1);
      end
      // Status keeps the last cost and program address
      apb(0, `PDSM_OFS_STAT, 0);
      chk(rd === {6'h00, xt[6][1:0], pa}, "stat fields");
      // Linear reads of Y addresses over the X path, word then odd byte
      rp = '0;
      for (i = 0; i < 2; i++) begin
         rq = '0;
         rq.kind = PDSM_K_DATA_RD;
         rq.byte_op = i[0];
         xa = {6'b000010, 9'($urandom), 1'b0};
         rq.ea_x = xa | 16'(i);
         w = {8'h00, xa ^ 16'hA55A};
         ex = '0;
         ex.x_data = i[0] ? {8'h00, w[15:8]} : w[15:0];
         send(4'b0100, 4'b1111, 1'b1);
      end
      // Dual-operand reads: good pointers, then Y pointer on X, X pointer on Y, X address in Y
      for (i = 0; i < 4; i++) begin
         rq = '0;
         rq.kind = PDSM_K_MAC_RD;
         rq.x_ptr = xps[i];
         rq.y_ptr = yps[i];
         xa = {6'b000000, 9'($urandom), 1'b0};
         ya = {6'b000010, 9'($urandom), 1'b0};
         rq.ea_x = xa | (i == 3 ? 16'h0800 : 16'h0400);
         xa = rq.ea_x;
         rq.ea_y = ya;
         ex = '0;
         ex.x_data = i[0] ? 16'h0000 : xa ^ 16'hA55A;
         ex.y_data = i == 2 ? 16'h0000 : ya ^ 16'h1234;
         send(i == 0 ? 4'b0101 : 4'b0000, i == 0 ? 4'b1111 : 4'b1000,
            1'b1);
      end
      apb(1, `PDSM_OFS_XMOD, {16'h0180, 16'h0100});
      apb(1, `PDSM_OFS_YMOD, {16'h0A00, 16'h0900});
      rq.x_ptr = 2'b00;
      rq.ea_x = 16'h0190;
      rq.mod_en = 1'b1;
      xa = 16'h0100;
      ex.x_data = xa ^ 16'hA55A;
      // Y pointer past its end wraps to the Y start as well
      rq.ea_y = 16'h0A10;
      ya = 16'h0900;
      ex.y_data = ya ^ 16'h1234;
      send(4'b0101, 4'b1111, 1'b1);
      // Window off: upper half is then unimplemented
      apb(1, `PDSM_OFS_CTRL, 32'h0);
      rq = '0;
      rq.kind = PDSM_K_DATA_RD;
      rq.ea_x = 16'h9000;
      ex = '0;
      send(4'b0000, 4'b1000, 1'b1);
      // Writes land on X only, a Y address included; then a bit-reversed one
      rq.kind = PDSM_K_DATA_WR;
      rq.ea_x = {6'b000010, 9'($urandom), 1'b0};
      rq.wdata = 16'($urandom);
      xa = rq.ea_x;
      send(4'b0010, 4'b1111, 1'b0);
      rq.brev_en = 1'b1;
      rq.ea_x = 16'h0002;
      xa = 16'h0100;
      send(4'b0010, 4'b1111, 1'b0);
      // Odd byte store: upper lane only, byte copied to both lanes
      rq.brev_en = 1'b0;
      rq.byte_op = 1'b1;
      rq.ea_x = 16'h0103;
      xa = 16'h0102;
      send(4'b0010, 4'b1111, 1'b0);
      conclude();
   end
endmodule

/* verif/pdsm_mem_model.sv */
// Program flash and X/Y RAM stand-ins, answering combinationally.
// Assumes the map holds its strobes and addresses for the read cycle.
`timescale 1ns/1ps

module pdsm_mem_model (
   input wire logic prog_rd,
   input wire logic [23:0] prog_addr,
   output logic [23:0] prog_word,
   input wire logic xram_rd,
   input wire logic [15:0] xram_addr,
   output logic [15:0] xram_rdata,
   input wire logic yram_rd,
   input wire logic [15:0] yram_addr,
   output logic [15:0] yram_rdata
);
   logic [23:0] pw;
   assign pw = {prog_addr[8:1] ^ 8'h5A, prog_addr[15:0] ^ 16'h3C96};
   // Idle lines show the inverse, so stale data never matches
   assign prog_word = prog_rd ? pw : ~pw;
   assign xram_rdata = xram_rd ? xram_addr ^ 16'hA55A : ~xram_addr;
   assign yram_rdata = yram_rd ? yram_addr ^ 16'h1234 : ~yram_addr;
endmodule
